// File: rtl/sync_neg_pkg.sv
// Shared constants and types for synchronous transfer negotiation
package sync_neg_pkg;
  localparam logic [7:0] FACTOR_FAST160 = 8'h08;
  localparam logic [7:0] FACTOR_FAST80 = 8'h09;
  localparam logic [7:0] FACTOR_FAST40 = 8'h0a;
  localparam logic [7:0] FACTOR_FAST20 = 8'h0c;
  localparam logic [7:0] FACTOR_FAST10 = 8'h19;
  localparam logic [7:0] FACTOR_FAST5 = 8'h32;
  localparam logic [7:0] MAX_OFFSET = 8'h3f;
  localparam logic [7:0] ASYNC_OFFSET = 8'h00;
  localparam logic [1:0] SYNC_STAGES = 2'h2;

  // Period in picoseconds for each accepted factor code
  localparam int PERIOD_PS_FAST160 = 6250;
  localparam int PERIOD_PS_FAST80 = 12500;
  localparam int PERIOD_PS_FAST40 = 25000;
  localparam int PERIOD_PS_FAST20 = 50000;
  localparam int PERIOD_PS_FAST10 = 100000;
  localparam int PERIOD_PS_FAST5 = 200000;

  typedef enum logic [2:0] {
    CLASS_ASYNC, CLASS_FAST5, CLASS_FAST10, CLASS_FAST20,
    CLASS_FAST40, CLASS_FAST80, CLASS_FAST160
  } xfer_class_e;

  typedef struct packed {
    logic [7:0] factor;
    logic [7:0] offset;
  } sync_terms_s;
endpackage

// File: rtl/sync_neg_target.sv
// Target side negotiation of synchronous period and offset
// Notes on behaviour
// - Period is settled by message exchange before any synchronous data phase uses it.
// - The period travels as a decimal factor code where 8, 9 and 10 mean 6.25, 12.5, 25 ns.
// - Codes 12, 25 and 50 are also accepted for 50, 100 and 200 ns periods.
// - Codes 8, 9 and 10 are allowed only while the port runs differential.
// - Offset never exceeds 63 and no larger value is ever offered.
// - The electrical mode is fixed and never changes while running.
// - Single-ended mode allows asynchronous and Fast-5 to Fast-20 only.
// - Differential mode allows asynchronous and every class up to Fast-160.
// - All devices on one segment share one electrical mode.
`timescale 1ns/1ns
module sync_neg_target (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic link_reset,
  input wire logic diff_mode_pin,
  input wire logic req_valid,
  input wire sync_neg_pkg::sync_terms_s req_terms,
  input wire logic data_phase_start,
  output logic reply_valid_r,
  output sync_neg_pkg::sync_terms_s reply_terms_r,
  output logic sync_active_r,
  output sync_neg_pkg::sync_terms_s active_terms_r,
  output sync_neg_pkg::xfer_class_e active_class_r,
  output logic diff_mode_r
);
  // Link-side mode sample; the mode is caught once and then frozen
  logic [1:0] mode_sync_r, mode_sync_nxt;
  logic mode_locked_r, mode_locked_nxt;
  logic diff_mode_nxt;

  always_comb begin
    mode_sync_nxt = {mode_sync_r[0], diff_mode_pin};
    mode_locked_nxt = 1'b1;
    // Later pin changes are ignored: switching live would corrupt a transfer
    diff_mode_nxt = mode_locked_r ? diff_mode_r : mode_sync_r[1];
  end

  always_ff @(posedge link_clk) begin
    // Synchroniser runs through reset so the strap is settled when reset lifts
    mode_sync_r <= mode_sync_nxt;
    if (link_reset) begin
      mode_locked_r <= 1'b0;
      diff_mode_r <= 1'b0;
    end else begin
      mode_locked_r <= mode_locked_nxt;
      diff_mode_r <= diff_mode_nxt;
    end
  end

  // Negotiation on the link clock
  sync_neg_pkg::sync_terms_s reply_terms_nxt;
  logic reply_valid_nxt;
  sync_neg_pkg::sync_terms_s agreed_r, agreed_nxt;
  logic agreed_ok_r, agreed_ok_nxt;
  logic [7:0] fac;
  logic [7:0] fac_out;

  always_comb begin
    fac = req_terms.factor;
    // Round up to the nearest slower supported period
    if (fac <= sync_neg_pkg::FACTOR_FAST160) begin
      fac_out = sync_neg_pkg::FACTOR_FAST160;
    end else if (fac == sync_neg_pkg::FACTOR_FAST80) begin
      fac_out = sync_neg_pkg::FACTOR_FAST80;
    end else if (fac == sync_neg_pkg::FACTOR_FAST40) begin
      fac_out = sync_neg_pkg::FACTOR_FAST40;
    end else if (fac <= sync_neg_pkg::FACTOR_FAST20) begin
      fac_out = sync_neg_pkg::FACTOR_FAST20;
    end else if (fac <= sync_neg_pkg::FACTOR_FAST10) begin
      fac_out = sync_neg_pkg::FACTOR_FAST10;
    end else if (fac <= sync_neg_pkg::FACTOR_FAST5) begin
      fac_out = sync_neg_pkg::FACTOR_FAST5;
    end else begin
      // Slower than Fast-5 has no synchronous class: fall back to asynchronous
      fac_out = sync_neg_pkg::FACTOR_FAST5;
    end
    // Single-ended caps at Fast-20
    if (!diff_mode_r && fac_out < sync_neg_pkg::FACTOR_FAST20) begin
      fac_out = sync_neg_pkg::FACTOR_FAST20;
    end
    reply_terms_nxt.factor = fac_out;
    if (fac > sync_neg_pkg::FACTOR_FAST5) begin
      reply_terms_nxt.offset = sync_neg_pkg::ASYNC_OFFSET;
    end else if (req_terms.offset > sync_neg_pkg::MAX_OFFSET) begin
      reply_terms_nxt.offset = sync_neg_pkg::MAX_OFFSET;
    end else begin
      reply_terms_nxt.offset = req_terms.offset;
    end
    reply_valid_nxt = req_valid;
    agreed_nxt = req_valid ? reply_terms_nxt : agreed_r;
    agreed_ok_nxt = agreed_ok_r | req_valid;
  end

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      reply_valid_r <= 1'b0;
      reply_terms_r <= '0;
      agreed_r <= '0;
      agreed_ok_r <= 1'b0;
    end else begin
      reply_valid_r <= reply_valid_nxt;
      reply_terms_r <= reply_terms_nxt;
      agreed_r <= agreed_nxt;
      agreed_ok_r <= agreed_ok_nxt;
    end
  end

  // Agreed terms and mode are carried to the core clock
  logic commit_pulse;
  logic [16:0] commit_word;
  logic core_pulse;
  logic [16:0] core_word;

  // Commit only when a data phase begins after agreement
  assign commit_pulse = data_phase_start & agreed_ok_r;
  assign commit_word = {diff_mode_r, agreed_r};

  sync_neg_toggle_xfer #(.WIDTH(17)) u_xfer (
    .src_clk(link_clk),
    .src_reset(link_reset),
    .src_pulse(commit_pulse),
    .src_data(commit_word),
    .dst_clk(ref_clk),
    .dst_reset(reset),
    .dst_pulse_r(core_pulse),
    .dst_data_r(core_word)
  );

  logic sync_active_nxt;
  sync_neg_pkg::sync_terms_s active_terms_nxt;
  sync_neg_pkg::xfer_class_e active_class_nxt;
  sync_neg_pkg::sync_terms_s cw;

  always_comb begin
    cw = core_word[15:0];
    sync_active_nxt = sync_active_r;
    active_terms_nxt = active_terms_r;
    active_class_nxt = active_class_r;
    if (core_pulse) begin
      sync_active_nxt = (cw.offset != sync_neg_pkg::ASYNC_OFFSET);
      active_terms_nxt = cw;
      case (cw.factor)
        sync_neg_pkg::FACTOR_FAST160: active_class_nxt = sync_neg_pkg::CLASS_FAST160;
        sync_neg_pkg::FACTOR_FAST80: active_class_nxt = sync_neg_pkg::CLASS_FAST80;
        sync_neg_pkg::FACTOR_FAST40: active_class_nxt = sync_neg_pkg::CLASS_FAST40;
        sync_neg_pkg::FACTOR_FAST20: active_class_nxt = sync_neg_pkg::CLASS_FAST20;
        sync_neg_pkg::FACTOR_FAST10: active_class_nxt = sync_neg_pkg::CLASS_FAST10;
        sync_neg_pkg::FACTOR_FAST5: active_class_nxt = sync_neg_pkg::CLASS_FAST5;
        default: active_class_nxt = sync_neg_pkg::CLASS_ASYNC;
      endcase
      if (cw.offset == sync_neg_pkg::ASYNC_OFFSET) begin
        active_class_nxt = sync_neg_pkg::CLASS_ASYNC;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync_active_r <= 1'b0;
      active_terms_r <= '0;
      active_class_r <= sync_neg_pkg::CLASS_ASYNC;
    end else begin
      sync_active_r <= sync_active_nxt;
      active_terms_r <= active_terms_nxt;
      active_class_r <= active_class_nxt;
    end
  end

  offset_cap_a: assert property (@(posedge link_clk) disable iff (link_reset)
    reply_valid_r |-> reply_terms_r.offset <= sync_neg_pkg::MAX_OFFSET)
    else $error("Offered offset above maximum");

  se_class_a: assert property (@(posedge link_clk) disable iff (link_reset)
    (reply_valid_r && !diff_mode_r) |-> reply_terms_r.factor >= sync_neg_pkg::FACTOR_FAST20)
    else $error("Fast class above Fast-20 offered in single-ended");

  slower_reply_a: assert property (@(posedge link_clk) disable iff (link_reset)
    req_valid && req_terms.factor <= sync_neg_pkg::FACTOR_FAST5
    |=> reply_valid_r && reply_terms_r.factor >= $past(req_terms.factor))
    else $error("Reply period faster than request");

  mode_frozen_a: assert property (@(posedge link_clk) disable iff (link_reset)
    $past(mode_locked_r) |-> $stable(diff_mode_r))
    else $error("Electrical mode changed while running");

  lvd_codes_a: assert property (@(posedge link_clk) disable iff (link_reset)
    (req_valid && diff_mode_r && req_terms.factor == sync_neg_pkg::FACTOR_FAST80
     && $past(mode_locked_r)) |=> reply_terms_r.factor == sync_neg_pkg::FACTOR_FAST80)
    else $error("Fast-80 refused in differential mode");

  fast20_code_a: assert property (@(posedge link_clk) disable iff (link_reset)
    (req_valid && req_terms.factor == 8'h0b) |=> reply_terms_r.factor == 8'h0c)
    else $error("Code 11 not rounded to 12");

  commit_after_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(sync_active_r) |-> $past(core_pulse))
    else $error("Synchronous mode without committed terms");

  class_match_a: assert property (@(posedge ref_clk) disable iff (reset)
    sync_active_r && active_terms_r.factor == sync_neg_pkg::FACTOR_FAST160
    |-> active_class_r == sync_neg_pkg::CLASS_FAST160)
    else $error("Class does not match factor");

  reply_pulse_a: assert property (@(posedge link_clk) disable iff (link_reset)
    req_valid |=> reply_valid_r)
    else $error("Request not answered");

  async_fallback_a: assert property (@(posedge link_clk) disable iff (link_reset)
    (req_valid && req_terms.factor > sync_neg_pkg::FACTOR_FAST5)
    |=> (reply_terms_r.factor == sync_neg_pkg::FACTOR_FAST5
         && reply_terms_r.offset == sync_neg_pkg::ASYNC_OFFSET))
    else $error("Slow request not answered asynchronously");

  lvd_fast160_a: assert property (@(posedge link_clk) disable iff (link_reset)
    (req_valid && diff_mode_r && req_terms.factor <= sync_neg_pkg::FACTOR_FAST160
     && $past(mode_locked_r)) |=> reply_terms_r.factor == sync_neg_pkg::FACTOR_FAST160)
    else $error("Fast-160 refused in differential mode");

  se_commit_a: assert property (@(posedge ref_clk) disable iff (reset)
    (core_pulse && !core_word[16]) |=> active_class_r <= sync_neg_pkg::CLASS_FAST20)
    else $error("Committed class above Fast-20 in single-ended");

  async_class_a: assert property (@(posedge ref_clk) disable iff (reset)
    !sync_active_r |-> active_class_r == sync_neg_pkg::CLASS_ASYNC)
    else $error("Asynchronous terms with a synchronous class");
endmodule

// File: rtl/sync_neg_toggle_xfer.sv
// Toggle handshake that carries a word from one clock domain to another
`timescale 1ns/1ns
module sync_neg_toggle_xfer #(
  parameter int WIDTH = 16
) (
  input wire logic src_clk,
  input wire logic src_reset,
  input wire logic src_pulse,
  input wire logic [WIDTH-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_reset,
  output logic dst_pulse_r,
  output logic [WIDTH-1:0] dst_data_r
);
  logic src_tog_r, src_tog_nxt;
  logic [WIDTH-1:0] src_hold_r, src_hold_nxt;
  logic [2:0] dst_sync_r, dst_sync_nxt;
  logic dst_pulse_nxt;
  logic [WIDTH-1:0] dst_data_nxt;

  // Held word stays still until the toggle is seen; callers space events apart
  always_comb begin
    src_tog_nxt = src_tog_r ^ src_pulse;
    src_hold_nxt = src_pulse ? src_data : src_hold_r;
  end

  always_ff @(posedge src_clk) begin
    if (src_reset) begin
      src_tog_r <= 1'b0;
      src_hold_r <= '0;
    end else begin
      src_tog_r <= src_tog_nxt;
      src_hold_r <= src_hold_nxt;
    end
  end

  // Only stage 2 and 3 are compared, stage 1 feeds stage 2 alone
  always_comb begin
    dst_sync_nxt = {dst_sync_r[1:0], src_tog_r};
    dst_pulse_nxt = dst_sync_r[2] ^ dst_sync_r[1];
    dst_data_nxt = dst_pulse_nxt ? src_hold_r : dst_data_r;
  end

  always_ff @(posedge dst_clk) begin
    if (dst_reset) begin
      dst_sync_r <= 3'h0;
      dst_pulse_r <= 1'b0;
      dst_data_r <= '0;
    end else begin
      dst_sync_r <= dst_sync_nxt;
      dst_pulse_r <= dst_pulse_nxt;
      dst_data_r <= dst_data_nxt;
    end
  end
endmodule

// File: tb/host_initiator_model.sv
// Initiator model that offers and commits transfer terms
`timescale 1ns/1ns
module host_initiator_model (
  input wire logic link_clk,
  input wire logic reply_valid_r,
  input wire sync_neg_pkg::sync_terms_s reply_terms_r,
  output logic req_valid,
  output sync_neg_pkg::sync_terms_s req_terms,
  output logic data_phase_start
);
  initial begin
    req_valid = 1'b0;
    req_terms = 16'h0000;
    data_phase_start = 1'b0;
  end
  // Gap makes slow offers; terms flip on release so stale data never matches
  task automatic offer(input sync_neg_pkg::sync_terms_s t, input int gap,
      output logic ok, output sync_neg_pkg::sync_terms_s r);
    repeat (gap) @(posedge link_clk);
    @(posedge link_clk);
    req_valid <= 1'b1;
    req_terms <= t;
    @(posedge link_clk);
    req_valid <= 1'b0;
    req_terms <= ~t;
    #1;
    ok = reply_valid_r;
    r = reply_terms_r;
  endtask
  // Spacing after the strobe lets the previous commit cross first
  task automatic commit();
    @(posedge link_clk);
    data_phase_start <= 1'b1;
    @(posedge link_clk);
    data_phase_start <= 1'b0;
    repeat (6) @(posedge link_clk);
  endtask
endmodule

// File: tb/sync_neg_target_tb.sv
// Self-checking bench for the target negotiation block
`timescale 1ns/1ns
module sync_neg_target_tb;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic link_reset = 1'b1;
  logic diff_mode_pin = 1'b1;
  logic req_valid, data_phase_start, reply_valid_r, sync_active_r, diff_mode_r;
  sync_neg_pkg::sync_terms_s req_terms, reply_terms_r, active_terms_r;
  sync_neg_pkg::xfer_class_e active_class_r;
  logic [7:0] factors [10] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h19, 8'h1a, 8'h32,
    8'h33};
  int num_errors = 0;
  int total_checks = 0;

  initial forever #10 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end

  sync_neg_target u_sync_neg_target (.ref_clk, .reset, .link_clk, .link_reset,
    .diff_mode_pin, .req_valid, .req_terms, .data_phase_start, .reply_valid_r,
    .reply_terms_r, .sync_active_r, .active_terms_r, .active_class_r, .diff_mode_r);
  host_initiator_model u_host_initiator_model (.link_clk, .reply_valid_r, .reply_terms_r,
    .req_valid, .req_terms, .data_phase_start);

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic sync_neg_pkg::sync_terms_s expect_reply(
      input sync_neg_pkg::sync_terms_s t, input logic d);
    sync_neg_pkg::sync_terms_s r;
    r.offset = (t.offset > 8'h3f) ? 8'h3f : t.offset;
    if (t.factor <= 8'h08) r.factor = 8'h08;
    else if (t.factor <= 8'h0a) r.factor = t.factor;
    else if (t.factor <= 8'h0c) r.factor = 8'h0c;
    else if (t.factor <= 8'h19) r.factor = 8'h19;
    else r.factor = 8'h32;
    if (t.factor > 8'h32) r.offset = 8'h00;
    if (!d && r.factor < 8'h0c) r.factor = 8'h0c;
    return r;
  endfunction

  // Both domains are reset so the mode strap is sampled afresh
  task automatic set_mode(input logic m);
    @(posedge link_clk);
    link_reset <= 1'b1;
    diff_mode_pin <= m;
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (5) @(posedge link_clk);
    link_reset <= 1'b0;
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge link_clk);
    check(16'(diff_mode_r), 16'(m), "mode");
  endtask

  task automatic test_rounding(input logic d);
    sync_neg_pkg::sync_terms_s t, r;
    logic ok;
    for (int i = 0; i < 10; i++) begin
      t = {factors[i], 8'(8'h3e + i)};
      u_host_initiator_model.offer(t, i % 2, ok, r);
      check(16'(ok), 16'h0001, "reply strobe");
      check(r, expect_reply(t, d), "reply");
    end
    $display("rounding test done, mode %0d", d);
  endtask

  task automatic test_commit(input logic d, input sync_neg_pkg::sync_terms_s t,
      input sync_neg_pkg::xfer_class_e c);
    sync_neg_pkg::sync_terms_s e, r;
    logic ok;
    e = expect_reply(t, d);
    u_host_initiator_model.offer(t, 0, ok, r);
    u_host_initiator_model.commit();
    check(active_terms_r, e, "committed terms");
    check(16'(active_class_r), 16'(c), "class");
    check(16'(sync_active_r), 16'(e.offset != 8'h00), "sync flag");
    $display("commit test done, factor %h", t.factor);
  endtask

  task automatic test_early_commit();
    u_host_initiator_model.commit();
    check(16'(active_class_r), 16'(sync_neg_pkg::CLASS_ASYNC), "early commit");
    check(16'(sync_active_r), 16'h0000, "early sync flag");
    $display("early commit test done");
  endtask

  task automatic test_mode_hold();
    sync_neg_pkg::sync_terms_s r;
    logic ok;
    @(posedge link_clk);
    diff_mode_pin <= 1'b0;
    repeat (6) @(posedge link_clk);
    check(16'(diff_mode_r), 16'h0001, "mode held");
    u_host_initiator_model.offer({8'h08, 8'h01}, 0, ok, r);
    check(r, 16'h0801, "fast reply after pin change");
    $display("mode hold test done");
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    set_mode(1'b1);
    test_early_commit();
    test_rounding(1'b1);
    test_commit(1'b1, {8'h08, 8'h10}, sync_neg_pkg::CLASS_FAST160);
    test_commit(1'b1, {8'h40, 8'h10}, sync_neg_pkg::CLASS_ASYNC);
    test_mode_hold();
    set_mode(1'b0);
    test_rounding(1'b0);
    test_commit(1'b0, {8'h08, 8'h50}, sync_neg_pkg::CLASS_FAST20);
    test_commit(1'b0, {8'h2a, 8'h3f}, sync_neg_pkg::CLASS_FAST5);
    finish_test();
  end
endmodule
